// >>> logic/load_monitor_pkg.sv
// Package with register map, field layout and carrier types of the load monitor status bank.
package load_monitor_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_WARN_SYS1 = 8'h34;
    localparam logic [7:0] IDX_ALARM_SYS1 = 8'h35;
    localparam logic [7:0] IDX_SETUP_SYS1 = 8'h36;
    localparam logic [7:0] IDX_WARN_SYS2 = 8'hfc;
    localparam logic [7:0] IDX_ALARM_SYS2 = 8'hfd;
    localparam logic [7:0] IDX_SETUP_SYS2 = 8'hfe;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
    localparam logic [7:0] IDX_MODE_FLAGS = 8'h42;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int REG_W = 16;
    localparam int AXIS_W = 14;
    localparam int SPINDLE1_BIT = 15;
    localparam int SPINDLE2_BIT = 14;
    localparam int ERR_NOT_REGISTERED = 0;
    localparam int ERR_ALARM_BELOW_WARN = 1;
    localparam int ERR_CAPACITY = 2;
    localparam int ERR_NO_TEACH_TIME = 3;
    localparam int ERR_TOL_INVERTED = 8;
    localparam int ERR_OVR_INVERTED = 9;
    localparam int ERR_BASE_AXIS = 10;
    localparam logic [15:0] SETUP_ERR_MASK = 16'h070f;

    // Interrupt status bits: per system warning, alarm and setup error.
    localparam int IRQ_W = 6;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [5:0] IRQ_RESET = 6'h00;

    typedef struct packed {
        logic [REG_W-1:0] warn;
        logic [REG_W-1:0] alarm;
        logic [REG_W-1:0] setup;
    } sys_bank_t;

    // Inputs from the sequence program and the monitoring logic, per system.
    typedef struct packed {
        logic runReq;
        logic teachSel;
        logic monitorSel;
        logic alarmClr;
        logic warnClr;
        logic [REG_W-1:0] warnExceed;
        logic [REG_W-1:0] alarmExceed;
        logic [REG_W-1:0] setupErr;
    } sys_in_t;

    typedef struct packed {
        logic running;
        logic teachActive;
        logic monitorActive;
    } sys_flags_t;

    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } avmm_req_t;

endpackage

// >>> logic/load_monitor_status_bank.sv
// Load monitor status bank for two part systems with an Avalon-MM slave.
// Function
// [R1] Monitor sets warning bit on warning exceed.
// [R2] Alarm or warning clear empties warning register.
// [R3] Dropping run request empties warning register.
// [R4] Monitor sets alarm bit on alarm exceed.
// [R5] Only alarm clear empties alarm register.
// [R6] Bitmaps hold first and second spindle bits.
// [R7] Bit 0: selected teaching data unregistered.
// [R8] Bit 1: alarm threshold below warning.
// [R9] Bit 2: teaching entries exceed capacity.
// [R10] Bit 3: no teaching time accumulated.
// [R11] Bit 8: upper tolerance below lower.
// [R12] Bit 9: maximum override below minimum.
// [R13] Bit 10: invalid base axis selection.
// [R14] Setup errors set; alarm clear empties.
// [R15] Sequence program drives run and clear inputs.
// [R16] Report running, teaching and monitor flags.
// [R17] Bits stay set until their clear.
`timescale 1ns/1ps

module load_monitor_status_bank #(
    parameter int NUM_SYS = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire load_monitor_pkg::sys_in_t sysIn [NUM_SYS],
    input wire load_monitor_pkg::avmm_req_t avs,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    output logic irq,
    output load_monitor_pkg::sys_flags_t sysFlags [NUM_SYS]
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        load_monitor_pkg::sys_bank_t [NUM_SYS-1:0] bank;
        load_monitor_pkg::sys_flags_t [NUM_SYS-1:0] flags;
        logic [load_monitor_pkg::IRQ_W-1:0] irqStatus;
        logic [load_monitor_pkg::IRQ_W-1:0] irqMask;
        logic [31:0] rdata;
        logic ack;
        logic irqOut;
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic [NUM_SYS-1:0] monActive;
    logic [load_monitor_pkg::IRQ_W-1:0] irqEvent;

    // ------------------------------------------------------------
    // Per-system status bits
    // ------------------------------------------------------------
    // The answer comes one cycle after the request is seen, so waitrequest
    // is high in the first cycle of every access and low in the second.
    always_comb begin
        logic [31:0] rd;
        logic [7:0] idx;
        rd = 32'h0000_0000;
        idx = avs.address;
        state_next = state_reg;
        irqEvent = '0;
        for (int s = 0; s < NUM_SYS; s++) begin
            monActive[s] = sysIn[s].runReq && sysIn[s].monitorSel;
            // [R16] Mode flags report.
            state_next.flags[s].running = sysIn[s].runReq;
            state_next.flags[s].teachActive = sysIn[s].runReq && sysIn[s].teachSel;
            state_next.flags[s].monitorActive = monActive[s];
            // [R2] [R3] Warning clears.
            if (sysIn[s].alarmClr || sysIn[s].warnClr || !sysIn[s].runReq) begin
                state_next.bank[s].warn = '0;
            end
            // [R1] [R6] [R17] Sticky warning set.
            if (monActive[s]) begin
                state_next.bank[s].warn = state_next.bank[s].warn | sysIn[s].warnExceed;
            end
            // [R5] Alarm clear only.
            if (sysIn[s].alarmClr) begin
                state_next.bank[s].alarm = '0;
                state_next.bank[s].setup = '0;
            end
            // [R4] [R6] [R17] Sticky alarm set.
            if (monActive[s]) begin
                state_next.bank[s].alarm = state_next.bank[s].alarm | sysIn[s].alarmExceed;
            end
            // [R7] [R8] [R9] [R10] [R11] [R12] [R13] [R14] Setup error set.
            state_next.bank[s].setup = state_next.bank[s].setup
                | (sysIn[s].setupErr & load_monitor_pkg::SETUP_ERR_MASK);
            irqEvent[3*s] = monActive[s] && (sysIn[s].warnExceed != '0);
            irqEvent[3*s+1] = monActive[s] && (sysIn[s].alarmExceed != '0);
            irqEvent[3*s+2] = (sysIn[s].setupErr & load_monitor_pkg::SETUP_ERR_MASK) != '0;
        end

        // --------------------------------------------------------
        // Bus slave
        // --------------------------------------------------------
        state_next.ack = (avs.read || avs.write) && !state_reg.ack;
        case (idx)
            load_monitor_pkg::IDX_WARN_SYS1: rd[15:0] = state_reg.bank[0].warn;
            load_monitor_pkg::IDX_ALARM_SYS1: rd[15:0] = state_reg.bank[0].alarm;
            load_monitor_pkg::IDX_SETUP_SYS1: rd[15:0] = state_reg.bank[0].setup;
            load_monitor_pkg::IDX_WARN_SYS2: rd[15:0] = state_reg.bank[NUM_SYS-1].warn;
            load_monitor_pkg::IDX_ALARM_SYS2: rd[15:0] = state_reg.bank[NUM_SYS-1].alarm;
            load_monitor_pkg::IDX_SETUP_SYS2: rd[15:0] = state_reg.bank[NUM_SYS-1].setup;
            load_monitor_pkg::IDX_IRQ_STATUS: rd[5:0] = state_reg.irqStatus;
            load_monitor_pkg::IDX_IRQ_MASK: rd[5:0] = state_reg.irqMask;
            load_monitor_pkg::IDX_MODE_FLAGS: rd[5:0] = {state_reg.flags[NUM_SYS-1],
                                                         state_reg.flags[0]};
            default: rd = 32'h0000_0000;
        endcase
        if (avs.read && !state_reg.ack) begin
            state_next.rdata = rd;
        end
        // The write lands at the edge where waitrequest is seen low, as the master expects.
        if (avs.write && state_reg.ack && idx == load_monitor_pkg::IDX_IRQ_MASK) begin
            state_next.irqMask = avs.writedata[load_monitor_pkg::IRQ_W-1:0];
        end
        // A read clears the status, but an event in the same cycle survives.
        if (avs.read && !state_reg.ack && idx == load_monitor_pkg::IDX_IRQ_STATUS) begin
            state_next.irqStatus = '0;
        end
        state_next.irqStatus = state_next.irqStatus | irqEvent;
        state_next.irqOut = (state_next.irqStatus & state_next.irqMask) != '0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign avsReaddata = state_reg.rdata;
    assign avsWaitrequest = !state_reg.ack;
    assign irq = state_reg.irqOut;
    for (genvar g = 0; g < NUM_SYS; g++) begin : gFlags
        assign sysFlags[g] = state_reg.flags[g];
    end

endmodule

// >>> test/load_monitor_status_bank_assertions.sv
// Assertions on the ports of the load monitor status bank.
`timescale 1ns/1ps
module load_monitor_status_bank_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire load_monitor_pkg::sys_in_t sysIn [2],
    input wire load_monitor_pkg::avmm_req_t avs,
    input wire logic [31:0] avsReaddata,
    input wire logic avsWaitrequest,
    input wire logic irq,
    input wire load_monitor_pkg::sys_flags_t sysFlags [2]
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic req;
    logic done;
    assign req = avs.read || avs.write;
    assign done = avs.read && !avsWaitrequest;
    a_run_flag: assert property (!$past(rst) |-> sysFlags[0].running == $past(sysIn[0].runReq))
        else $error("run flag wrong");
    a_teach_flag: assert property (sysFlags[0].teachActive |-> $past(sysIn[0].teachSel))
        else $error("teach flag wrong");
    a_mon_flag: assert property (sysIn[1].runReq && sysIn[1].monitorSel |=> sysFlags[1].monitorActive)
        else $error("monitor flag wrong");
    a_wait_answer: assert property (req && avsWaitrequest |=> !avsWaitrequest)
        else $error("no answer");
    a_wait_single: assert property (!avsWaitrequest |=> avsWaitrequest)
        else $error("long answer");
    a_idle_wait: assert property (!req |=> avsWaitrequest)
        else $error("answer without request");
    a_upper_zero: assert property (done |-> avsReaddata[31:16] == 16'h0000)
        else $error("upper data set");
    a_setup_rsvd: assert property (done && avs.address == load_monitor_pkg::IDX_SETUP_SYS1 |->
        (avsReaddata[15:0] & ~load_monitor_pkg::SETUP_ERR_MASK) == 16'h0000)
        else $error("reserved setup bit");
    c_read: cover property (done);
    c_irq: cover property ($rose(irq));
    c_mon: cover property (sysFlags[0].monitorActive);
endmodule
bind load_monitor_status_bank load_monitor_status_bank_assertions u_chk (.clk(clk), .rst(rst),
    .sysIn(sysIn), .avs(avs), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .irq(irq), .sysFlags(sysFlags));

// >>> test/seq_program_model.sv
// Model of the sequence program that drives the monitor inputs.
`timescale 1ns/1ps
module seq_program_model (
    input wire logic clk,
    input wire load_monitor_pkg::sys_in_t cmd [2],
    output load_monitor_pkg::sys_in_t sysIn [2]
);
    always_ff @(posedge clk) sysIn <= cmd;
endmodule

// >>> test/tb_top.sv
// Self-checking testbench of the load monitor status bank.
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    load_monitor_pkg::sys_in_t cmd [2] = '{default: '0};
    load_monitor_pkg::sys_in_t sysIn [2];
    load_monitor_pkg::avmm_req_t avs = '0;
    load_monitor_pkg::sys_flags_t sysFlags [2];
    logic [31:0] avsReaddata, rd;
    logic avsWaitrequest, irq;
    logic [15:0] w, a, s;
    logic [7:0] b;
    logic [4:0] m;
    int miscompares = 0, total_checks = 0, seed = 9;
    initial forever #2.5 clk = ~clk;
    seq_program_model u_seq (.clk(clk), .cmd(cmd), .sysIn(sysIn));
    load_monitor_status_bank u_dut (.clk(clk), .rst(rst), .sysIn(sysIn), .avs(avs),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .irq(irq),
        .sysFlags(sysFlags));
    task automatic complete_run();
        if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, e);
        total_checks++;
        if (got !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, got);
        end
    endtask
    // Holds the request until waitrequest is seen low at an edge.
    task automatic bus(input logic [7:0] ad, input logic wr, input logic [15:0] wd);
        @(posedge clk);
        avs <= '{ad, !wr, wr, {16'h0000, wd}};
        do @(posedge clk); while (avsWaitrequest !== 1'b0);
        rd = avsReaddata;
        avs <= '0;
    endtask
    task automatic rdck(input logic [7:0] ad, input logic [31:0] e);
        bus(ad, 1'b0, 16'h0000);
        chk($sformatf("reg %h", ad), rd, e);
    endtask
    task automatic put(input int k, input logic [4:0] c, input logic [15:0] x, y, z);
        @(posedge clk);
        cmd[k] <= {c, x, y, z};
    endtask
    function automatic logic [31:0] ix(input int k, input logic [15:0] x, y, z);
        return 32'({|(z & load_monitor_pkg::SETUP_ERR_MASK), |y, |x}) << (3 * k);
    endfunction
    initial begin
        #100000;
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            b = k ? 8'hfc : 8'h34;
            m = {1'b1, k[0], 1'b1, 2'b00};
            w = 16'($random(seed));
            a = 16'($random(seed));
            s = k ? 16'hffff : 16'($random(seed));
            bus(8'h40, 1'b0, 16'h0000);
            bus(8'h41, 1'b1, 16'h003f);
            rdck(8'h41, 32'h3f);
            put(k, m, w, a, s);
            put(k, m, '0, '0, '0);
            repeat (3) @(posedge clk);
            rdck(8'h42, k ? 32'h38 : 32'h05);
            chk("irq", irq, 32'(|ix(k, w, a, s)));
            rdck(b, 32'(w));
            rdck(b + 8'h01, 32'(a));
            rdck(b + 8'h02, 32'(s & load_monitor_pkg::SETUP_ERR_MASK));
            rdck(8'h40, ix(k, w, a, s));
            repeat (2) @(posedge clk);
            chk("irq", irq, 32'h0);
            bus(8'h41, 1'b1, 16'h0000);
            put(k, m | 5'b00001, '0, '0, '0);
            put(k, m, '0, '0, '0);
            repeat (3) @(posedge clk);
            rdck(b, 32'h0);
            rdck(b + 8'h01, 32'(a));
            put(k, m, w, '0, '0);
            put(k, 5'b00000, '0, '0, '0);
            bus(b, 1'b1, 16'hffff);
            rdck(b, 32'h0);
            chk("irq", irq, 32'h0);
            put(k, 5'b00010, '0, '0, '0);
            put(k, 5'b00000, '0, '0, '0);
            repeat (3) @(posedge clk);
            rdck(b + 8'h01, 32'h0);
            rdck(b + 8'h02, 32'h0);
        end
        rdck(8'h00, 32'h0);
        complete_run();
    end
endmodule
